/* File: src/gio_pkg.sv */
// How it works
// - Writing busy in input mode starts one character read
// - Character held: busy clears, done sets
// - Data-in returns data; in input mode rearms busy, clears done
// - Conditions-out loads channel into low bits
// - Done raises request on assigned channel
// - Conditions-out word loads channel and mode; done is kept
// - Pending device rerequests after channel dismissal
// - Output device starts on first data-out
// - Conditions-out clearing busy stops next read
// - Respond only to own seven-bit device number
// - Conditions-in returns control and status bits
package gio_pkg;

  localparam int unsigned WORD_W = 36;
  localparam int unsigned CHAR_W = 8;
  localparam int unsigned DEV_W  = 7;
  localparam int unsigned CHAN_W = 3;
  localparam int unsigned NCHAN  = 7;

  // Arbitrary value for this device's bus number
  localparam logic [DEV_W-1:0] generic_device_code = 7'h2a;

  // Control register layout, low end of the bus word
  localparam int unsigned CHAN_LSB = 0;
  localparam int unsigned BUSY_BIT = 3;
  localparam int unsigned DONE_BIT = 4;
  localparam int unsigned MODE_BIT = 5;
  localparam int unsigned CTRL_W   = 6;

  localparam logic [CHAN_W-1:0] CHAN_NONE  = 3'h0;
  localparam logic [CHAR_W-1:0] DATA_RESET = 8'h00;

  typedef enum logic [1:0] {
    conditions_out_cmd,
    conditions_in_cmd,
    data_out_cmd,
    data_in_cmd
  } io_kind_t;

  typedef struct packed {
    logic              valid;
    io_kind_t          kind;
    logic [DEV_W-1:0]  dev;
    logic [WORD_W-1:0] word;
  } io_cmd_t;

  typedef struct packed {
    logic              valid;
    logic [WORD_W-1:0] word;
  } io_rsp_t;

  typedef struct packed {
    logic              mode_out;
    logic              done;
    logic              busy;
    logic [CHAN_W-1:0] chan;
  } ctrl_t;

  typedef struct packed {
    ctrl_t             ctrl;
    logic [CHAR_W-1:0] data;
    io_rsp_t           rsp;
    logic [NCHAN-1:0]  pi_req;
  } dev_state_t;

endpackage : gio_pkg

/* File: src/char_skid_buffer.sv */
`timescale 1ns/1ps
module char_skid_buffer #(
  parameter int unsigned W = 8
) (
  // Clock and reset
  input  wire logic         core_clk,
  input  wire logic         rst,
  // Fill side
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  // Drain side
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);

  typedef struct packed {
    logic [1:0][W-1:0] slot;
    logic              head;
    logic [1:0]        count;
  } buf_state_t;

  buf_state_t st;
  buf_state_t next_st;
  logic       push;
  logic       pop;

  assign in_ready  = (st.count != 2'h2);
  assign out_valid = (st.count != 2'h0);
  assign out_data  = st.slot[st.head];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb
  begin
    next_st = st;
    if (push)
    begin
      next_st.slot[st.head ^ st.count[0]] = in_data;
    end
    if (pop)
    begin
      next_st.head = ~st.head;
    end
    next_st.count = st.count + {1'b0, push} - {1'b0, pop};
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

endmodule : char_skid_buffer

/* File: src/generic_io_device.sv */
`timescale 1ns/1ps
module generic_io_device (
  // Clock and reset
  input  wire logic                   core_clk,
  input  wire logic                   rst,
  // Processor I/O bus
  input  wire gio_pkg::io_cmd_t       cmd,
  output gio_pkg::io_rsp_t            rsp,
  output logic [gio_pkg::NCHAN-1:0]   pi_req,
  // Peripheral character source
  input  wire logic                   char_in_valid,
  output logic                        char_in_ready,
  input  wire logic [gio_pkg::CHAR_W-1:0] char_in,
  // Peripheral character sink
  output logic                        char_out_valid,
  input  wire logic                   char_out_ready,
  output logic [gio_pkg::CHAR_W-1:0]  char_out,
  // Status view
  output logic                        busy,
  output logic                        done
);
  import gio_pkg::*;

  dev_state_t        st;
  dev_state_t        next_st;
  logic              hit;
  logic              drain_valid;
  logic              drain_ready;
  logic [CHAR_W-1:0] drain_data;
  logic              took_in;
  logic              took_out;

  // The source side is same-clock logic, so no synchroniser is needed
  char_skid_buffer #(
    .W (CHAR_W)
  ) u_in_buf (
    .core_clk  (core_clk),
    .rst       (rst),
    .in_valid  (char_in_valid),
    .in_ready  (char_in_ready),
    .in_data   (char_in),
    .out_valid (drain_valid),
    .out_ready (drain_ready),
    .out_data  (drain_data)
  );

  assign hit = cmd.valid && (cmd.dev == generic_device_code);

  // Reads pause in a command cycle so a command never races a completion
  assign drain_ready    = st.ctrl.busy && !st.ctrl.mode_out && !hit;
  assign took_in        = drain_valid && drain_ready;
  assign char_out_valid = st.ctrl.busy && st.ctrl.mode_out && !hit;
  assign took_out       = char_out_valid && char_out_ready;
  assign char_out       = st.data;

  assign rsp    = st.rsp;
  assign pi_req = st.pi_req;
  assign busy   = st.ctrl.busy;
  assign done   = st.ctrl.done;

  always_comb
  begin
    next_st           = st;
    next_st.rsp.valid = 1'b0;
    if (hit)
    begin
      case (cmd.kind)
        conditions_out_cmd:
        begin
          next_st.ctrl.chan     = cmd.word[CHAN_LSB +: CHAN_W];
          next_st.ctrl.mode_out = cmd.word[MODE_BIT];
          if (!cmd.word[BUSY_BIT])
          begin
            next_st.ctrl.busy = 1'b0;
          end
          else if (!cmd.word[MODE_BIT])
          begin
            next_st.ctrl.busy = 1'b1;
          end
        end
        conditions_in_cmd:
        begin
          next_st.rsp.valid = 1'b1;
          next_st.rsp.word  = {{(WORD_W-CTRL_W){1'b0}}, st.ctrl};
        end
        data_in_cmd:
        begin
          next_st.rsp.valid = 1'b1;
          next_st.rsp.word  = {{(WORD_W-CHAR_W){1'b0}}, st.data};
          if (!st.ctrl.mode_out)
          begin
            next_st.ctrl.busy = 1'b1;
            next_st.ctrl.done = 1'b0;
          end
        end
        data_out_cmd:
        begin
          if (st.ctrl.mode_out)
          begin
            next_st.data      = cmd.word[CHAR_W-1:0];
            next_st.ctrl.busy = 1'b1;
            next_st.ctrl.done = 1'b0;
          end
        end
        default:
        begin
          next_st.rsp.valid = 1'b0;
        end
      endcase
    end
    if (took_in)
    begin
      next_st.data      = drain_data;
      next_st.ctrl.busy = 1'b0;
      next_st.ctrl.done = 1'b1;
    end
    if (took_out)
    begin
      next_st.ctrl.busy = 1'b0;
      next_st.ctrl.done = 1'b1;
    end
    // Level request: a shared channel sees it again once dismissed
    next_st.pi_req = '0;
    if (next_st.ctrl.done && (next_st.ctrl.chan != CHAN_NONE))
    begin
      next_st.pi_req[next_st.ctrl.chan - 3'h1] = 1'b1;
    end
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  chk_read_completes: assert property (took_in |=> !busy && done && st.data == $past(drain_data))
    else $error("character taken but flags or data wrong");

  chk_data_in_cmd_rearm: assert property (hit && cmd.kind == data_in_cmd && !st.ctrl.mode_out
    |=> busy && !done && rsp.valid)
    else $error("data-in did not rearm the read");

  chk_data_in_cmd_word: assert property (hit && cmd.kind == data_in_cmd
    |=> rsp.word[CHAR_W-1:0] == $past(st.data) && rsp.word[WORD_W-1:CHAR_W] == '0)
    else $error("data-in returned the wrong word");

  chk_conditions_out_cmd_chan: assert property (hit && cmd.kind == conditions_out_cmd
    |=> st.ctrl.chan == $past(cmd.word[CHAN_W-1:0]))
    else $error("channel field not loaded");

  chk_conditions_out_cmd_start: assert property (hit && cmd.kind == conditions_out_cmd
    && cmd.word[BUSY_BIT] && !cmd.word[MODE_BIT] |=> busy)
    else $error("input read not started");

  chk_out_waits: assert property (hit && cmd.kind == conditions_out_cmd && cmd.word[MODE_BIT]
    && !busy |=> !busy)
    else $error("output device started without data-out");

  chk_conditions_out_cmd_stop: assert property (hit && cmd.kind == conditions_out_cmd && !cmd.word[BUSY_BIT]
    |=> !busy ##1 !took_in)
    else $error("read continued after busy cleared");

  chk_conditions_in_cmd_status: assert property (hit && cmd.kind == conditions_in_cmd
    |=> rsp.valid && rsp.word[CTRL_W-1:0] == $past(st.ctrl))
    else $error("conditions-in returned wrong status");

  chk_foreign_quiet: assert property (cmd.valid && cmd.dev != generic_device_code && !took_in
    && !took_out |=> !rsp.valid && $stable(st.ctrl))
    else $error("device answered a foreign number");

  chk_irq_held: assert property (done && st.ctrl.chan != CHAN_NONE
    |-> $onehot(pi_req) && pi_req[st.ctrl.chan - 3'h1])
    else $error("request missing while done");

  chk_irq_none: assert property (st.ctrl.chan == CHAN_NONE || !done |-> pi_req == '0)
    else $error("request raised without assignment");

  chk_irq_rise: assert property ($rose(done) && st.ctrl.chan != CHAN_NONE |-> pi_req != '0)
    else $error("request late after done rose");

  chk_out_start: assert property (hit && cmd.kind == data_out_cmd && st.ctrl.mode_out
    |=> busy && !done && st.data == $past(cmd.word[CHAR_W-1:0]))
    else $error("data-out did not start the output");

  chk_out_finish: assert property (took_out |=> !busy && done)
    else $error("output handshake did not finish");

  // An input device must ignore data-out entirely, flags and data alike
  chk_data_out_cmd_ignored: assert property (hit && cmd.kind == data_out_cmd && !st.ctrl.mode_out
    |=> $stable(st.ctrl) && $stable(st.data))
    else $error("input device reacted to data-out");

  chk_idle_no_read: assert property (!busy |-> !drain_ready)
    else $error("read taken while not busy");

  chk_foreign_data: assert property (cmd.valid && cmd.dev != generic_device_code && !took_in
    && !took_out |=> $stable(st.data))
    else $error("foreign command changed the data");

  chk_conditions_in_cmd_quiet: assert property (hit && cmd.kind == conditions_in_cmd |=> $stable(st.ctrl))
    else $error("conditions-in changed the flags");

  chk_data_in_cmd_out_mode: assert property (hit && cmd.kind == data_in_cmd && st.ctrl.mode_out
    |=> rsp.valid && $stable(st.ctrl))
    else $error("data-in in output mode changed flags");

  // Answers only ever follow a read-type command addressed to us
  chk_rsp_cause: assert property (rsp.valid |-> $past(hit && (cmd.kind == conditions_in_cmd
    || cmd.kind == data_in_cmd)))
    else $error("answer without a read command");

  // Reset is checked while held, so the usual disable is overridden here
  chk_reset_clear: assert property (@(posedge core_clk) disable iff (1'b0)
    rst |-> !busy && !done && st.ctrl.chan == CHAN_NONE && st.data == DATA_RESET)
    else $error("reset left state behind");

endmodule : generic_io_device

/* File: sim/proc_model.sv */
`timescale 1ns/1ps
module proc_model
  import gio_pkg::*;
(
  // Clock and reset
  input  wire logic                  core_clk,
  input  wire logic                  rst,
  // I/O bus
  output gio_pkg::io_cmd_t           cmd,
  input  wire gio_pkg::io_rsp_t      rsp,
  input  wire logic [gio_pkg::NCHAN-1:0] pi_req
);
  logic [WORD_W-1:0] rd_word;
  logic              rd_seen;
  int unsigned       vector;
  logic [NCHAN-1:0]  active;
  logic [WORD_W-1:0] save_word;

  initial
  begin
    cmd = '0;
    active = '0;
  end

  // Lowest channel scanned last wins, so channel 1 outranks the rest;
  // a channel in service blocks itself and every higher-numbered one
  always_comb
  begin
    vector = 0;
    for (int j = NCHAN; j >= 1; j--)
      if (pi_req[j-1] === 1'b1 && (active & ((7'h01 << j) - 7'h01)) == 7'h00)
        vector = 40 + 2 * j;
  end

  task automatic take_break(input int unsigned j, input logic [WORD_W-1:0] pc);
    active[j-1] = 1'b1;
    save_word = pc;
    @(negedge core_clk);
  endtask : take_break

  task automatic restore(input logic [3:0] ac, output logic [WORD_W-1:0] pc);
    logic [NCHAN-1:0] top;
    top = active & (~active + 7'h01);
    pc = save_word;
    if (ac[3])
      active = active & ~top;
    @(negedge core_clk);
  endtask : restore

  task automatic skip_if_any_status_one(input logic [DEV_W-1:0] d,
                                        input logic [WORD_W-1:0] mask, output logic skip);
    issue(conditions_in_cmd, d, 36'h0);
    skip = rd_seen && ((rd_word & mask) != 36'h0);
  endtask : skip_if_any_status_one

  task automatic block_input(input logic [DEV_W-1:0] d, inout logic [WORD_W-1:0] ptr,
                             input int unsigned j, output logic skip,
                             output int unsigned next_loc);
    logic last;
    ptr = {ptr[WORD_W-1:18] + 18'h00001, ptr[17:0] + 18'h00001};
    issue(data_in_cmd, d, 36'h0);
    last = (ptr[WORD_W-1:18] == 18'h00000);
    skip = !last && (j == 0);
    next_loc = 0;
    if (j != 0)
    begin
      if (last)
        next_loc = 41 + 2 * j;
      else
        active[j-1] = 1'b0;
    end
  endtask : block_input

  task automatic issue(input io_kind_t k, input logic [DEV_W-1:0] d,
                       input logic [WORD_W-1:0] w);
    @(negedge core_clk);
    cmd <= '{valid: 1'b1, kind: k, dev: d, word: w};
    @(negedge core_clk);
    cmd.valid <= 1'b0;
    rd_seen = 1'b0;
    // The answer pulse lasts one cycle, so it is looked at every cycle
    repeat (2)
    begin
      if (rsp.valid === 1'b1)
      begin
        rd_seen = 1'b1;
        rd_word = rsp.word;
      end
      @(negedge core_clk);
    end
  endtask : issue
endmodule : proc_model

/* File: sim/tb.sv */
`timescale 1ns/1ps
module tb;
  import gio_pkg::*;
  logic              core_clk;
  logic              rst;
  io_cmd_t           cmd;
  io_rsp_t           rsp;
  logic [NCHAN-1:0]  pi_req;
  logic              in_valid;
  logic              in_ready;
  logic [CHAR_W-1:0] in_data;
  logic              out_valid;
  logic              out_ready;
  logic [CHAR_W-1:0] out_data;
  logic              busy;
  logic              done;
  logic              acc;
  logic              sk;
  logic [WORD_W-1:0] pc_w;
  logic [WORD_W-1:0] ptr;
  int unsigned       nl;
  int                errors;
  int                comparisons;
  localparam logic [DEV_W-1:0] me = generic_device_code;

  generic_io_device dut_u (.core_clk(core_clk), .rst(rst), .cmd(cmd), .rsp(rsp),
    .pi_req(pi_req), .char_in_valid(in_valid), .char_in_ready(in_ready),
    .char_in(in_data), .char_out_valid(out_valid), .char_out_ready(out_ready),
    .char_out(out_data), .busy(busy), .done(done));
  proc_model proc_u (.core_clk(core_clk), .rst(rst), .cmd(cmd), .rsp(rsp),
    .pi_req(pi_req));

  initial
  begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  task automatic chk(input string n, input logic [WORD_W-1:0] e,
                     input logic [WORD_W-1:0] g);
    comparisons++;
    if (g !== e)
    begin
      errors++;
      $display("unexpected %s: expected %h, seen %h", n, e, g);
    end
  endtask : chk

  task automatic push(input logic [CHAR_W-1:0] c);
    @(negedge core_clk);
    acc = in_ready;
    in_valid = 1'b1;
    in_data = c;
    @(negedge core_clk);
    in_valid = 1'b0;
  endtask : push

  task automatic wait_done;
    for (int i = 0; i < 8 && done !== 1'b1; i++)
      @(negedge core_clk);
  endtask : wait_done

  task automatic summarize;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : summarize

  initial
  begin
    #20000;
    errors++;
    summarize();
  end

  initial
  begin
    errors = 0;
    comparisons = 0;
    rst = 1'b1;
    in_valid = 1'b0;
    in_data = '0;
    out_ready = 1'b0;
    repeat (16) @(posedge core_clk);
    @(negedge core_clk);
    rst = 1'b0;
    chk("reset", 36'h0, 36'({busy, done, pi_req, out_data}));
    $display("end reset");
    proc_u.issue(conditions_out_cmd, me ^ 7'h01, 36'h009);
    chk("busy", 36'h0, 36'(busy));
    proc_u.issue(conditions_in_cmd, me ^ 7'h01, 36'h0);
    chk("answer", 36'h0, 36'(proc_u.rd_seen));
    $display("end address");
    proc_u.issue(conditions_out_cmd, me, 36'h009);
    chk("busy", 36'h1, 36'(busy));
    proc_u.issue(conditions_in_cmd, me, 36'h0);
    chk("control", 36'h009, proc_u.rd_word);
    push(8'h5a);
    wait_done();
    chk("flags", 36'h1, 36'({busy, done}));
    chk("pi_req", 36'h01, 36'(pi_req));
    chk("vector", 36'd42, 36'(proc_u.vector));
    proc_u.skip_if_any_status_one(me, 36'h010, sk);
    chk("skip", 36'h1, 36'(sk));
    proc_u.take_break(1, 36'h100);
    chk("vector", 36'd0, 36'(proc_u.vector));
    proc_u.restore(4'd2, pc_w);
    chk("vector", 36'd0, 36'(proc_u.vector));
    proc_u.restore(4'd10, pc_w);
    chk("return", 36'h100, pc_w);
    chk("vector", 36'd42, 36'(proc_u.vector));
    proc_u.issue(data_in_cmd, me, 36'h0);
    chk("data", 36'h05a, proc_u.rd_word);
    chk("flags", 36'h2, 36'({busy, done}));
    chk("pi_req", 36'h0, 36'(pi_req));
    $display("end input");
    proc_u.issue(conditions_out_cmd, me, 36'h001);
    push(8'ha1);
    push(8'ha2);
    push(8'ha3);
    chk("refused", 36'h0, 36'(acc));
    chk("flags", 36'h0, 36'({busy, done}));
    proc_u.issue(conditions_out_cmd, me, 36'h008);
    wait_done();
    chk("pi_req", 36'h0, 36'(pi_req));
    ptr = {18'h3fffe, 18'h000ff};
    proc_u.block_input(me, ptr, 0, sk, nl);
    chk("data", 36'h0a1, proc_u.rd_word);
    chk("skip", 36'h1, 36'(sk));
    wait_done();
    proc_u.take_break(1, 36'h0);
    proc_u.block_input(me, ptr, 1, sk, nl);
    chk("data", 36'h0a2, proc_u.rd_word);
    chk("pointer", {18'h00000, 18'h00101}, ptr);
    chk("next", 36'd43, 36'(nl));
    chk("active", 36'h1, 36'(proc_u.active));
    proc_u.restore(4'd10, pc_w);
    $display("end stall");
    proc_u.issue(conditions_out_cmd, me, 36'h000);
    proc_u.issue(conditions_out_cmd, me, 36'h028);
    chk("busy", 36'h0, 36'(busy));
    proc_u.issue(data_out_cmd, me, 36'h03c);
    chk("out", 36'h13c, 36'({out_valid, out_data}));
    out_ready = 1'b1;
    @(negedge core_clk);
    out_ready = 1'b0;
    @(negedge core_clk);
    chk("flags", 36'h1, 36'({busy, done}));
    $display("end output");
    summarize();
  end
endmodule : tb
